// File: rtl/xiob_pkg.sv
package xiob_pkg;

    // ==========================================================
    // register map in external data space (byte addresses)
    localparam logic [15:0] PA_DATA_ADDR = 16'h0000;
    localparam logic [15:0] PA_DIR_ADDR = 16'h0001;
    localparam logic [15:0] BANK_ADDR = 16'h0002;
    localparam logic [15:0] PB_DATA_ADDR = 16'h0003;
    localparam logic [15:0] PB_DIR_ADDR = 16'h0004;
    localparam logic [15:0] CHIP_SELECT_PIN_ENABLE_ADDR = 16'h0005;
    localparam logic [15:0] WAKE_ADDR = 16'h0006;
    // addresses whose upper byte equals this page never raise a chip select
    localparam logic [7:0] INTERNAL_PAGE = 8'h00;

    // ==========================================================
    // reset values
    localparam logic [7:0] PA_DATA_RST = 8'h00;
    localparam logic [7:0] PA_DIR_RST = 8'hff;
    localparam logic [7:0] BANK_RST = 8'h00;
    localparam logic [7:0] PB_DATA_RST = 8'h00;
    localparam logic [7:0] PB_DIR_RST = 8'hff;
    localparam logic [7:0] CHIP_SELECT_PIN_ENABLE_RST = 8'hff;
    localparam logic [7:0] WAKE_RST = 8'h60;
    localparam logic [7:0] CS_IDLE = 8'hff;
    localparam logic [7:0] PA_FORCED_IN = 8'hff;

    // ==========================================================
    // field positions
    localparam int BANK_EN_BIT = 2;
    localparam int BANK_CODE_HI = 1;
    localparam int BANK_CODE_LO = 0;
    localparam int PA_A16_BIT = 7;
    localparam int WAKE_EN_BIT = 7;
    localparam int WAKE_PIN0_BIT = 6;
    localparam int WAKE_PIN1_BIT = 5;
    localparam int WAKE_POL0_BIT = 4;
    localparam int WAKE_POL1_BIT = 3;
    localparam int WAKE_EDGE0_BIT = 2;
    localparam int WAKE_EDGE1_BIT = 1;
    localparam int WAKE_AND_BIT = 0;
    localparam int WAKE_CFG_W = 5;

    // bank code values
    localparam logic [1:0] BANK_CODE_0 = 2'h0;
    localparam logic [1:0] BANK_CODE_1 = 2'h1;
    localparam logic [1:0] BANK_CODE_2 = 2'h2;

endpackage : xiob_pkg

// File: rtl/xiob_wake_latch.sv
`timescale 1ns/1ps

// ==========================================================
// edge catcher clocked by the polarity-adjusted wake pin itself
module xiob_wake_latch (
    // edge source
    input wire logic edge_in,
    // low clears and holds cleared
    input wire logic arm,
    // caught edge
    output logic caught
);

    typedef struct packed {
        logic caught;
    } xiob_latch_type;

    xiob_latch_type s_reg;
    xiob_latch_type s_next;

    // any rising edge sets the latch, no filtering at all
    always_comb begin
        s_next = s_reg;
        s_next.caught = 1'b1;
    end

    // runs with the core clock stopped, so no clk is involved
    always_ff @(posedge edge_in or negedge arm) begin
        if (!arm) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign caught = s_reg.caught;

endmodule : xiob_wake_latch

// File: rtl/xiob_top.sv
`timescale 1ns/1ps

module xiob_top (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // external data bus from the core
    input wire logic [15:0] xaddr,
    input wire logic [7:0] xwdata,
    input wire logic xwr,
    input wire logic xrd,
    output logic [7:0] xrdata,
    // program address remapping
    input wire logic fetch,
    input wire logic a15_in,
    output logic a15_out,
    // port A pins
    input wire logic [7:0] pa_in,
    output logic [7:0] pa_out,
    output logic [7:0] pa_oe,
    // port B pins and chip selects
    input wire logic [7:0] pb_in,
    output logic [7:0] pb_out,
    output logic [7:0] pb_oe,
    // wake pins and power-down handshake
    input wire logic [1:0] wake_pin,
    input wire logic power_down,
    output logic wake_request
);

    // ==========================================================
    // state
    // every flop of the block lives in this one struct; the comb process
    // below builds the next copy and a single clocked process stores it.
    // the pin synchronisers sit in the same struct so that all of them
    // share the one asynchronous reset and no stray flop is left out.
    // limitation: the two wake edge latches cannot live here, because
    // they must keep working while clk is stopped in power-down.
    typedef struct packed {
        logic [7:0] pa_data;
        logic [7:0] pa_dir;
        logic pa_dir_written;
        logic [7:0] bank;
        logic [7:0] pb_data;
        logic [7:0] pb_dir;
        logic [7:0] chip_select_pin_enable;
        logic [xiob_pkg::WAKE_CFG_W:0] wake_cfg;
        logic [7:0] pa_s1;
        logic [7:0] pa_s2;
        logic [7:0] pb_s1;
        logic [7:0] pb_s2;
        logic [1:0] wk_s1;
        logic [1:0] wk_s2;
        logic [7:0] cs_n;
        logic a15;
        logic a16;
        logic [7:0] rdata;
        logic pd;
    } xiob_state_type;

    localparam xiob_state_type RESET_STATE = '{
        pa_data: xiob_pkg::PA_DATA_RST,
        pa_dir: xiob_pkg::PA_DIR_RST,
        bank: xiob_pkg::BANK_RST,
        pb_data: xiob_pkg::PB_DATA_RST,
        pb_dir: xiob_pkg::PB_DIR_RST,
        chip_select_pin_enable: xiob_pkg::CHIP_SELECT_PIN_ENABLE_RST,
        wake_cfg: {xiob_pkg::WAKE_RST[xiob_pkg::WAKE_EN_BIT],
                   xiob_pkg::WAKE_RST[xiob_pkg::WAKE_CFG_W-1:0]},
        cs_n: xiob_pkg::CS_IDLE,
        default: '0
    };

    xiob_state_type s_reg;
    xiob_state_type s_next;

    // ==========================================================
    // decode helpers
    // the select windows double in size from pin to pin, so the pin to
    // use is simply the highest set bit of the upper address byte.
    // a priority scan is cheaper than eight range compares and can never
    // raise two selects at once, which keeps wire-or'ed selects safe.
    function automatic logic [7:0] cs_decode(input logic [15:0] a);
        logic [7:0] hi;
        logic [7:0] sel;
        hi = a[15:8];
        sel = 8'h00;
        // highest set bit of the upper byte picks exactly one window
        for (int k = 0; k < 8; k++) begin
            if (hi[k]) begin
                sel = 8'h01 << k;
            end
        end
        // upper byte zero is the internal page, sel stays empty
        return ~sel;
    endfunction : cs_decode

    // control fields picked out of the stored registers by name, so the
    // logic below never carries a bare bit position
    wire logic bank_en = s_reg.bank[xiob_pkg::BANK_EN_BIT];
    wire logic [1:0] bank_code = {s_reg.bank[xiob_pkg::BANK_CODE_HI],
                                  s_reg.bank[xiob_pkg::BANK_CODE_LO]};
    wire logic wake_en = s_reg.wake_cfg[xiob_pkg::WAKE_CFG_W];
    wire logic pol0 = s_reg.wake_cfg[xiob_pkg::WAKE_POL0_BIT];
    wire logic pol1 = s_reg.wake_cfg[xiob_pkg::WAKE_POL1_BIT];
    wire logic edge0 = s_reg.wake_cfg[xiob_pkg::WAKE_EDGE0_BIT];
    wire logic edge1 = s_reg.wake_cfg[xiob_pkg::WAKE_EDGE1_BIT];
    wire logic and_en = s_reg.wake_cfg[xiob_pkg::WAKE_AND_BIT];

    // port A input view: forced ones until software sets direction
    wire logic [7:0] pa_view = s_reg.pa_dir_written ? s_reg.pa_s2
                                                    : xiob_pkg::PA_FORCED_IN;
    // wake inputs read as ones while the input circuitry is off
    wire logic [1:0] wk_view = wake_en ? s_reg.wk_s2 : 2'h3;

    wire logic [7:0] wake_read = {wake_en, wk_view[0], wk_view[1],
                                  s_reg.wake_cfg[xiob_pkg::WAKE_CFG_W-1:0]};

    // ==========================================================
    // next state
    always_comb begin
        s_next = s_reg;
        // two-flop synchronisers on every pin input
        s_next.pa_s1 = pa_in;
        s_next.pa_s2 = s_reg.pa_s1;
        s_next.pb_s1 = pb_in;
        s_next.pb_s2 = s_reg.pb_s1;
        s_next.wk_s1 = wake_pin;
        s_next.wk_s2 = s_reg.wk_s1;
        s_next.pd = power_down;

        // register writes from external data moves
        // a write lands at the strobe edge and is visible the next cycle.
        // the full 16-bit address is compared, so nothing above 0006
        // aliases onto a register; such writes raise a select only outside page 00.
        // a strobe held for several cycles repeats the same write, which
        // is harmless because every register here is plain storage.
        if (xwr) begin
            unique case (xaddr)
                xiob_pkg::PA_DATA_ADDR: s_next.pa_data = xwdata;
                xiob_pkg::PA_DIR_ADDR: begin
                    s_next.pa_dir = xwdata;
                    s_next.pa_dir_written = 1'b1;
                end
                xiob_pkg::BANK_ADDR: s_next.bank = xwdata;
                xiob_pkg::PB_DATA_ADDR: s_next.pb_data = xwdata;
                xiob_pkg::PB_DIR_ADDR: s_next.pb_dir = xwdata;
                xiob_pkg::CHIP_SELECT_PIN_ENABLE_ADDR: s_next.chip_select_pin_enable = xwdata;
                xiob_pkg::WAKE_ADDR: begin
                    s_next.wake_cfg = {xwdata[xiob_pkg::WAKE_EN_BIT],
                                       xwdata[xiob_pkg::WAKE_CFG_W-1:0]};
                end
                default: begin
                end
            endcase
        end

        // read data, one cycle after the strobe; unmapped reads as zero
        // port data reads return the synchronised pins, not the stored data
        // (port A reads ones until its direction is written), so a pin change shows two to three cycles late.
        // read data drops back to zero one cycle after the strobe goes away,
        // which keeps a stale byte from looking like a fresh answer.
        s_next.rdata = 8'h00;
        if (xrd) begin
            unique case (xaddr)
                xiob_pkg::PA_DATA_ADDR: s_next.rdata = pa_view;
                xiob_pkg::PA_DIR_ADDR: s_next.rdata = s_reg.pa_dir;
                xiob_pkg::BANK_ADDR: s_next.rdata = s_reg.bank;
                xiob_pkg::PB_DATA_ADDR: s_next.rdata = s_reg.pb_s2;
                xiob_pkg::PB_DIR_ADDR: s_next.rdata = s_reg.pb_dir;
                xiob_pkg::CHIP_SELECT_PIN_ENABLE_ADDR: s_next.rdata = s_reg.chip_select_pin_enable;
                xiob_pkg::WAKE_ADDR: s_next.rdata = wake_read;
                default: s_next.rdata = 8'h00;
            endcase
        end

        // selects only during a cycle, all high between cycles
        // the select is registered, so it follows the strobe by one cycle
        // and returns high one cycle after the strobe drops.
        // the internal register page never raises any select, so parts
        // on the external bus cannot answer on top of our own registers.
        if ((xrd || xwr) && (xaddr[15:8] != xiob_pkg::INTERNAL_PAGE)) begin
            s_next.cs_n = cs_decode(xaddr);
        end else begin
            s_next.cs_n = xiob_pkg::CS_IDLE;
        end

        // program address remapping
        // both address bits come from flops, so they follow fetch and
        // internal A15 by one cycle; the trade is a glitch-free address
        // against one cycle of extra latency on the remapped lines.
        // outside fetch cycles A15 passes and A16 is held low.
        s_next.a15 = a15_in;
        s_next.a16 = 1'b0;
        if (bank_en && fetch) begin
            if (!a15_in) begin
                s_next.a15 = 1'b0;
                s_next.a16 = 1'b0;
            end else begin
                unique case (bank_code)
                    xiob_pkg::BANK_CODE_0: {s_next.a15, s_next.a16} = 2'b10;
                    xiob_pkg::BANK_CODE_1: {s_next.a15, s_next.a16} = 2'b01;
                    xiob_pkg::BANK_CODE_2: {s_next.a15, s_next.a16} = 2'b11;
                    default: {s_next.a15, s_next.a16} = 2'b01;
                endcase
            end
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_reg <= RESET_STATE;
        end else begin
            s_reg <= s_next;
        end
    end

    // ==========================================================
    // pin drivers
    // enables and drive values are decoded from stored state only, so a
    // pin never toggles on a bus strobe that is still settling.
    // port B select pins always drive, even while their select is idle,
    // because an idle select must read as a solid high to its device.
    always_comb begin
        // port A: floats until direction written, except pin 7 while banking is enabled
        pa_oe = s_reg.pa_dir_written ? ~s_reg.pa_dir : 8'h00;
        pa_out = s_reg.pa_data;
        if (bank_en) begin
            pa_oe[xiob_pkg::PA_A16_BIT] = 1'b1;
            pa_out[xiob_pkg::PA_A16_BIT] = s_reg.a16;
        end
        // port B: select enable overrides data and direction
        pb_oe = s_reg.chip_select_pin_enable | ~s_reg.pb_dir;
        pb_out = (s_reg.chip_select_pin_enable & s_reg.cs_n) | (~s_reg.chip_select_pin_enable & s_reg.pb_data);
    end

    assign xrdata = s_reg.rdata;
    assign a15_out = s_reg.a15;

    // ==========================================================
    // wakeup path
    // the raw pins are used here on purpose: the clock is stopped in
    // power-down, so nothing synchronised could see the pin move
    // hazard: edges are not filtered, so a short glitch on a wake pin
    // wakes the core; boards must keep these lines quiet in power-down.
    // the edge latches are cleared whenever the core is awake, so only
    // edges seen inside power-down can raise a request.
    // the level term needs no latch: it stands as long as the pins do.
    logic [1:0] adj;
    logic [1:0] caught;
    logic [1:0] arm;
    logic [1:0] edge_on;

    // disabled inputs are held high, then polarity is applied
    assign adj[0] = (wake_en ? wake_pin[0] : 1'b1) ^ pol0;
    assign adj[1] = (wake_en ? wake_pin[1] : 1'b1) ^ pol1;
    assign edge_on = {edge1, edge0};

    // latches armed only while the core sits in power-down
    // one latch per wake pin, each clocked by its own adjusted level
    generate
        for (genvar i = 0; i < 2; i++) begin : g_wake
            assign arm[i] = nrst & s_reg.pd & wake_en & edge_on[i];
            xiob_wake_latch u_latch (
                .edge_in(adj[i]),
                .arm(arm[i]),
                .caught(caught[i])
            );
        end
    endgenerate

    // request stays up until the core leaves power-down and disarms
    assign wake_request = wake_en & (caught[0] | caught[1] | (and_en & adj[0] & adj[1]));

endmodule : xiob_top

// File: dv/xiob_core_model.sv
`timescale 1ns/1ps

// ==========================================================
// core side of the external data bus, one access at a time
module xiob_core_model (
    // clock
    input wire logic clk,
    // external data bus
    output logic [15:0] xaddr,
    output logic [7:0] xwdata,
    output logic xwr,
    output logic xrd,
    input wire logic [7:0] xrdata,
    // program fetch address
    output logic fetch,
    output logic a15_in
);
    // idle bus at time zero
    initial begin
        xaddr = 16'h0000;
        xwdata = 8'h00;
        xwr = 1'b0;
        xrd = 1'b0;
        fetch = 1'b0;
        a15_in = 1'b0;
    end

    // write cycle; released lines flip so stale values never pass as valid
    task wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk);
        #1 xaddr = a;
        xwdata = v;
        xwr = 1'b1;
        @(posedge clk);
        #1 xwr = 1'b0;
        xaddr = ~a;
        xwdata = ~v;
    endtask : wr

    // read cycle; data is registered and shows the cycle after the strobe
    task rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge clk);
        #1 xaddr = a;
        xrd = 1'b1;
        @(posedge clk);
        #1 xrd = 1'b0;
        xaddr = ~a;
        v = xrdata;
    endtask : rd

    // fetch qualifier and internal A15
    task fch(input logic f, input logic a);
        @(posedge clk);
        #1 fetch = f;
        a15_in = a;
    endtask : fch
endmodule : xiob_core_model

// File: dv/xiob_chk.sv
`timescale 1ns/1ps

// ==========================================================
// port-level checker of the io bank
module xiob_chk (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // bus and fetch
    input wire logic [15:0] xaddr,
    input wire logic [7:0] xwdata,
    input wire logic xwr,
    input wire logic xrd,
    input wire logic fetch,
    input wire logic a15_in,
    // pins
    input wire logic a15_out,
    input wire logic [7:0] pa_out,
    input wire logic [7:0] pa_oe,
    input wire logic [7:0] pb_out,
    input wire logic [7:0] pb_oe,
    input wire logic [1:0] wake_pin,
    input wire logic wake_request
);
    logic [7:0] chip_select_pin_enable_q, bank_q, wake_q, cs_exp;

    // shadow copies of the control registers, seen only through writes
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            chip_select_pin_enable_q <= xiob_pkg::CHIP_SELECT_PIN_ENABLE_RST;
            bank_q <= xiob_pkg::BANK_RST;
            wake_q <= 8'h00;
        end else if (xwr) begin
            if (xaddr == xiob_pkg::CHIP_SELECT_PIN_ENABLE_ADDR) chip_select_pin_enable_q <= xwdata;
            if (xaddr == xiob_pkg::BANK_ADDR) bank_q <= xwdata;
            if (xaddr == xiob_pkg::WAKE_ADDR) wake_q <= xwdata;
        end
    end

    // expected selects: highest set bit of the upper byte wins
    always_comb begin
        cs_exp = 8'hff;
        for (int i = 0; i < 8; i++) begin
            if (xaddr[8 + i]) cs_exp = ~(8'h01 << i);
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    // non-select pins are masked off with ~chip_select_pin_enable_q
    a_cs_decode: assert property ((xrd | xwr) |=>
        (pb_out | ~chip_select_pin_enable_q) == ($past(cs_exp) | ~chip_select_pin_enable_q)) else $error("bad select");
    a_cs_reserved: assert property ((xrd | xwr) && xaddr[15:8] == 8'h00 |=>
        &(pb_out | ~chip_select_pin_enable_q)) else $error("select in reserved page");
    a_cs_release: assert property (!(xrd | xwr) |=> &(pb_out | ~chip_select_pin_enable_q))
        else $error("select not released");
    a_cs_single: assert property ($countones(~pb_out & chip_select_pin_enable_q) <= 1)
        else $error("two selects low");
    a_cs_drive: assert property ((pb_oe & chip_select_pin_enable_q) == chip_select_pin_enable_q)
        else $error("select pin not driven");
    a_bank_pass: assert property (!bank_q[2] |=> a15_out == $past(a15_in))
        else $error("A15 altered");
    a_bank_map: assert property (bank_q[2] && fetch && a15_in |=>
        a15_out == ($past(bank_q[1:0]) inside {2'h0, 2'h2}) &&
        pa_out[7] == ($past(bank_q[1:0]) != 2'h0)) else $error("bank map");
    a_bank_low: assert property (bank_q[2] && fetch && !a15_in |=>
        !a15_out && !pa_out[7]) else $error("low bank not zero");
    a_bank_oe: assert property (bank_q[2] |-> pa_oe[7]) else $error("A16 pin");
    a_wake_and: assert property (wake_q[7] && wake_q[0] && (wake_pin[0] ^ wake_q[4]) &&
        (wake_pin[1] ^ wake_q[3]) |-> wake_request) else $error("no level wake");
    a_wake_off: assert property (!wake_q[7] |-> !wake_request)
        else $error("wake while disabled");
endmodule : xiob_chk

bind xiob_top xiob_chk xiob_chk_i (.clk(clk), .nrst(nrst), .xaddr(xaddr),
    .xwdata(xwdata), .xwr(xwr), .xrd(xrd), .fetch(fetch), .a15_in(a15_in),
    .a15_out(a15_out), .pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out), .pb_oe(pb_oe),
    .wake_pin(wake_pin), .wake_request(wake_request));

// File: dv/test_ext_mapped_io_bank_cs_wakeup.sv
`timescale 1ns/1ps

// ==========================================================
// directed bench driven through the core model
module test_ext_mapped_io_bank_cs_wakeup;
    logic clk, nrst, xwr, xrd, fetch, a15_in, a15_out, power_down, wake_request;
    logic [15:0] xaddr;
    logic [7:0] xwdata, xrdata, pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe, d;
    logic [1:0] wake_pin;
    int failures, n_checks, k;
    logic [15:0] ra [6] = '{16'h0000, 16'h0002, 16'h0004, 16'h0005, 16'h0006, 16'h0007};
    logic [7:0] re [6] = '{8'hff, 8'h00, 8'hff, 8'hff, 8'h60, 8'h00};

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    xiob_top DUT (.clk(clk), .nrst(nrst), .xaddr(xaddr), .xwdata(xwdata), .xwr(xwr),
        .xrd(xrd), .xrdata(xrdata), .fetch(fetch), .a15_in(a15_in), .a15_out(a15_out),
        .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .pb_in(pb_in), .pb_out(pb_out),
        .pb_oe(pb_oe), .wake_pin(wake_pin), .power_down(power_down),
        .wake_request(wake_request));
    xiob_core_model core (.clk(clk), .xaddr(xaddr), .xwdata(xwdata), .xwr(xwr),
        .xrd(xrd), .xrdata(xrdata), .fetch(fetch), .a15_in(a15_in));

    // byte compare
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task rdc(input logic [15:0] a, input logic [7:0] e);
        core.rd(a, d);
        chk(d, e);
    endtask : rdc
    task finish_test;
        $display("failures %0d n_checks %0d", failures, n_checks);
        if (failures == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    // a hang counts as a mismatch
    initial begin
        #1000000;
        failures++;
        finish_test;
    end

    initial begin
        nrst = 1'b0;
        power_down = 1'b0;
        wake_pin = 2'b00;
        pa_in = 8'ha5;
        pb_in = 8'h5a;
        failures = 0;
        n_checks = 0;
        cyc(8);
        nrst = 1'b1;
        chk(pa_oe, 8'h00);
        chk(pb_out & pb_oe, 8'hff);
        for (k = 0; k < 6; k++) rdc(ra[k], re[k]);
        // both ends of every select window
        for (k = 0; k < 8; k++) begin
            core.rd(16'h0100 << k, d);
            chk(pb_out, ~(8'h01 << k));
            core.rd((16'h0200 << k) - 16'h0001, d);
            chk(pb_out, ~(8'h01 << k));
        end
        cyc(1);
        chk(pb_out, 8'hff);
        core.rd(16'h00ff, d);
        chk(pb_out, 8'hff);
        // low nibble stays selects, high nibble plain io
        core.wr(16'h0005, 8'h0f);
        core.wr(16'h0004, 8'h3c);
        core.wr(16'h0003, 8'h96);
        rdc(16'h0003, 8'h5a);
        chk(pb_oe, 8'hcf);
        core.rd(16'h0800, d);
        chk(pb_out, 8'h97);
        core.wr(16'h0002, 8'hf8);
        rdc(16'h0002, 8'hf8);
        chk(pa_oe, 8'h00);
        // every bank code, A15 high then low
        for (k = 0; k < 4; k++) begin
            core.wr(16'h0002, 8'h04 | k[7:0]);
            core.fch(1'b1, 1'b1);
            cyc(1);
            chk({6'h00, pa_out[7], a15_out}, {6'h00, k != 0, k == 0 || k == 2});
            core.fch(1'b1, 1'b0);
            cyc(1);
            chk({6'h00, pa_out[7], a15_out}, 8'h00);
        end
        chk(pa_oe, 8'h80);
        core.fch(1'b0, 1'b1);
        cyc(1);
        chk({6'h00, pa_out[7], a15_out}, 8'h01);
        // code 1 but disabled: pin 7 must follow data, not A16
        core.wr(16'h0002, 8'h01);
        core.wr(16'h0001, 8'h7f);
        core.fch(1'b1, 1'b1);
        cyc(1);
        chk({pa_oe[7], pa_out[7], a15_out, 5'h00}, 8'ha0);
        rdc(16'h0000, 8'ha5);
        // wake pins read back, then level and edge wake
        core.wr(16'h0006, 8'h80);
        wake_pin = 2'b01;
        cyc(3);
        rdc(16'h0006, 8'hc0);
        core.wr(16'h0006, 8'h01);
        wake_pin = 2'b11;
        cyc(3);
        rdc(16'h0006, 8'h61);
        chk({7'h00, wake_request}, 8'h00);
        core.wr(16'h0006, 8'h99);
        chk({7'h00, wake_request}, 8'h00);
        wake_pin = 2'b00;
        #1 chk({7'h00, wake_request}, 8'h01);
        core.wr(16'h0006, 8'h9a);
        wake_pin = 2'b10;
        power_down = 1'b1;
        cyc(2);
        chk({7'h00, wake_request}, 8'h00);
        // falling pulse of 1 ns must still be caught and held
        #5 wake_pin = 2'b00;
        #1 wake_pin = 2'b10;
        #1 chk({7'h00, wake_request}, 8'h01);
        power_down = 1'b0;
        cyc(2);
        chk({7'h00, wake_request}, 8'h00);
        finish_test;
    end
endmodule : test_ext_mapped_io_bank_cs_wakeup
